// ===== rtl/compare_channel_cfg.svh
`ifndef COMPARE_CHANNEL_CFG_SVH
`define COMPARE_CHANNEL_CFG_SVH

// Register indices on the plain register port
`define ADDR_CONTROL        3'h0
`define ADDR_PRIMARY        3'h1
`define ADDR_SECONDARY      3'h2
`define ADDR_STATUS         3'h3

// Control register field positions
`define CTL_MODE_LSB        0
`define CTL_TSEL_BIT        3
`define CTL_FAULT_BIT       4
`define CTL_IDLE_BIT        13
`define CTL_WRITE_MASK      16'h200F

// Status register field positions
`define STS_PIN_BIT         0
`define STS_EVENT_BIT       1
`define STS_DONE_BIT        2

// Reset values
`define RST_CONTROL         16'h0000
`define RST_COMPARE         16'h0000

`endif

// ===== rtl/compare_channel_pkg.sv
package compare_channel_pkg;

	typedef enum logic [2:0] {
		MODE_OFF      = 3'h0,
		MODE_SET_HIGH = 3'h1,
		MODE_SET_LOW  = 3'h2,
		MODE_TOGGLE   = 3'h3,
		MODE_ONE_PULSE = 3'h4,
		MODE_PULSES   = 3'h5,
		MODE_PWM      = 3'h6,
		MODE_PWM_FLT  = 3'h7
	} compare_mode_e;

	typedef logic [15:0] word_t;

endpackage

// ===== rtl/input_sync.sv
`timescale 1ns/1ps
`include "compare_channel_cfg.svh"

module input_sync
	import compare_channel_pkg::*;
(
	// Clock and reset
	input  wire logic CLK_SYS,
	input  wire logic RST_B,
	// Pin in, filtered level out
	input  wire logic pin,
	output logic      level
);

	typedef struct packed {
		logic [2:0] stage;
		logic       level;
	} sync_s;

	sync_s r;
	sync_s next_r;

	always_comb begin
		next_r = r;
		next_r.stage = {r.stage[1:0], pin};
		// Change only once second and third stage agree
		if (r.stage[1] == r.stage[2]) begin
			next_r.level = r.stage[2];
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign level = r.level;

endmodule // input_sync

// ===== rtl/edge_event.sv
`timescale 1ns/1ps
`include "compare_channel_cfg.svh"

module edge_event
	import compare_channel_pkg::*;
(
	// Clock and reset
	input  wire logic CLK_SYS,
	input  wire logic RST_B,
	// Level to watch and edge selection
	input  wire logic level,
	input  wire logic on_rise,
	input  wire logic on_fall,
	// One-cycle event
	output logic      event_pulse
);

	typedef struct packed {
		logic last;
	} edge_s;

	edge_s r;
	edge_s next_r;

	always_comb begin
		next_r.last = level;
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign event_pulse = (on_rise && level && !r.last) || (on_fall && !level && r.last);

endmodule // edge_event

// ===== rtl/output_compare_channel.sv
// Notes on behaviour
// - Select bit one picks second timer
// - Compare timer against one or two registers
// - Mode zero: disabled, port owns pin
// - Mode one: start low, match sets high
// - Mode two: start high, match sets low
// - Mode three: keep level, match toggles
// - Mode four: single pulse between matches
// - Mode five: repeating pulses between matches
// - Mode six: PWM, no fault, no interrupt
// - Mode seven: PWM, fault falling edge interrupts
// - Fault flag hardware set, read only
// - Idle stop bit halts channel in idle
// - Unimplemented control bits read zero
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "compare_channel_cfg.svh"

module output_compare_channel
	import compare_channel_pkg::*;
#(
	parameter int TIMER_WIDTH = 16
) (
	// Clock and reset
	input  wire logic                   CLK_SYS,
	input  wire logic                   RST_B,
	// Register port
	input  wire logic [2:0]             REG_ADDR,
	input  wire logic [15:0]            REG_WDATA,
	input  wire logic                   REG_WRITE,
	input  wire logic                   REG_READ,
	output logic      [15:0]            REG_RDATA,
	// Time bases
	input  wire logic [TIMER_WIDTH-1:0] FIRST_TIMER,
	input  wire logic                   FIRST_TIMER_ROLLOVER,
	input  wire logic [TIMER_WIDTH-1:0] SECOND_TIMER,
	input  wire logic                   SECOND_TIMER_ROLLOVER,
	// Processor state and fault pin
	input  wire logic                   CPU_IDLE,
	input  wire logic                   SHARED_FAULT_INPUT,
	// Output pin
	output logic                        COMPARE_OUTPUT_PIN,
	output logic                        COMPARE_OUTPUT_ENABLE,
	output logic                        COMPARE_EVENT
);

	// Compare values and duty are one word wide; wider timers cannot be served
	if (TIMER_WIDTH != 16) begin : g_width_check
		$error("output_compare_channel: TIMER_WIDTH must be 16");
	end

	typedef struct packed {
		logic          idle_stop;
		logic          time_base_select;
		logic          pwm_fault_flag;
		compare_mode_e mode;
		word_t         primary_compare_value;
		word_t         secondary_compare_value;
		word_t         duty;
		logic          pin;
		logic          pulse_done;
		logic          event_seen;
		logic [15:0]   rdata;
	} chan_s;

	chan_s r;
	chan_s next_r;

	logic  fault_level;
	logic  fault_fall;
	logic  pin_event;
	logic  ev_rise;
	logic  ev_fall;
	word_t timer;
	logic  rollover;
	logic  halted;
	logic  match_pri;
	logic  match_sec;
	logic  ctl_write;

	input_sync u_fault_sync (
		.CLK_SYS (CLK_SYS),
		.RST_B   (RST_B),
		.pin     (SHARED_FAULT_INPUT),
		.level   (fault_level)
	);

	edge_event u_fault_edge (
		.CLK_SYS     (CLK_SYS),
		.RST_B       (RST_B),
		.level       (fault_level),
		.on_rise     (1'b0),
		.on_fall     (1'b1),
		.event_pulse (fault_fall)
	);

	edge_event u_pin_edge (
		.CLK_SYS     (CLK_SYS),
		.RST_B       (RST_B),
		.level       (r.pin),
		.on_rise     (ev_rise),
		.on_fall     (ev_fall),
		.event_pulse (pin_event)
	);

	// Timer value and rollover of the chosen base
	assign timer    = r.time_base_select ? SECOND_TIMER : FIRST_TIMER;
	assign rollover = r.time_base_select ? SECOND_TIMER_ROLLOVER : FIRST_TIMER_ROLLOVER;
	assign halted   = r.idle_stop && CPU_IDLE;
	assign match_pri = !halted && (timer == r.primary_compare_value);
	assign match_sec = !halted && (timer == r.secondary_compare_value);
	assign ctl_write = REG_WRITE && (REG_ADDR == `ADDR_CONTROL);

	// Interrupt edge choice per mode
	always_comb begin
		ev_rise = 1'b0;
		ev_fall = 1'b0;
		unique case (r.mode)
			MODE_OFF: begin
				ev_rise = 1'b0;
			end
			MODE_SET_HIGH: begin
				ev_rise = 1'b1;
			end
			MODE_SET_LOW: begin
				ev_fall = 1'b1;
			end
			MODE_TOGGLE: begin
				ev_rise = 1'b1;
				ev_fall = 1'b1;
			end
			MODE_ONE_PULSE, MODE_PULSES: begin
				ev_fall = 1'b1;
			end
			MODE_PWM, MODE_PWM_FLT: begin
				ev_fall = 1'b0;
			end
		endcase
	end

	always_comb begin
		next_r = r;
		// Mode rewrite loads the documented initial pin state
		if (ctl_write) begin
			next_r.idle_stop        = REG_WDATA[`CTL_IDLE_BIT];
			next_r.time_base_select = REG_WDATA[`CTL_TSEL_BIT];
			next_r.mode             = compare_mode_e'(REG_WDATA[`CTL_MODE_LSB +: 3]);
			next_r.pwm_fault_flag   = 1'b0;
			next_r.pulse_done       = 1'b0;
			unique case (compare_mode_e'(REG_WDATA[`CTL_MODE_LSB +: 3]))
				MODE_OFF: begin
					next_r.pin = 1'b0;
				end
				MODE_SET_HIGH, MODE_ONE_PULSE, MODE_PULSES: begin
					next_r.pin = 1'b0;
				end
				MODE_SET_LOW: begin
					next_r.pin = 1'b1;
				end
				MODE_TOGGLE: begin
					next_r.pin = r.pin;
				end
				MODE_PWM, MODE_PWM_FLT: begin
					next_r.pin = (r.primary_compare_value != 16'h0000);
					next_r.duty = r.primary_compare_value;
					// Fault in the rewrite cycle still wins over the clear
					if (compare_mode_e'(REG_WDATA[`CTL_MODE_LSB +: 3]) == MODE_PWM_FLT
						&& fault_fall) begin
						next_r.pwm_fault_flag = 1'b1;
						next_r.pin            = 1'b0;
					end
				end
			endcase
		end else begin
			unique case (r.mode)
				MODE_OFF: begin
					next_r.pin = 1'b0;
				end
				MODE_SET_HIGH: begin
					if (match_pri) begin
						next_r.pin = 1'b1;
					end
				end
				MODE_SET_LOW: begin
					if (match_pri) begin
						next_r.pin = 1'b0;
					end
				end
				MODE_TOGGLE: begin
					if (match_pri) begin
						next_r.pin = !r.pin;
					end
				end
				MODE_ONE_PULSE, MODE_PULSES: begin
					// Primary raises, secondary lowers
					if (match_sec && r.pin) begin
						next_r.pin = 1'b0;
						next_r.pulse_done = (r.mode == MODE_ONE_PULSE);
					end else if (match_pri && !r.pulse_done) begin
						next_r.pin = 1'b1;
					end
				end
				MODE_PWM, MODE_PWM_FLT: begin
					// Duty reload only at period boundary avoids glitches
					if (!halted && rollover) begin
						next_r.duty = r.secondary_compare_value;
						next_r.pin  = (r.secondary_compare_value != 16'h0000);
					end else if (!halted && timer == r.duty) begin
						next_r.pin = 1'b0;
					end
					if (r.mode == MODE_PWM_FLT && (fault_fall || r.pwm_fault_flag)) begin
						next_r.pwm_fault_flag = 1'b1;
						next_r.pin = 1'b0;
					end
				end
			endcase
		end
		// Compare values written by software
		if (REG_WRITE && REG_ADDR == `ADDR_PRIMARY) begin
			next_r.primary_compare_value = REG_WDATA;
		end
		if (REG_WRITE && REG_ADDR == `ADDR_SECONDARY) begin
			next_r.secondary_compare_value = REG_WDATA;
		end
		// Sticky event; set wins over read clear
		if (COMPARE_EVENT) begin
			next_r.event_seen = 1'b1;
		end else if (REG_READ && REG_ADDR == `ADDR_STATUS) begin
			next_r.event_seen = 1'b0;
		end
		next_r.rdata = 16'h0000;
		if (REG_READ) begin
			unique case (REG_ADDR)
				`ADDR_CONTROL: begin
					next_r.rdata[`CTL_IDLE_BIT]  = r.idle_stop;
					next_r.rdata[`CTL_FAULT_BIT] = r.pwm_fault_flag;
					next_r.rdata[`CTL_TSEL_BIT]  = r.time_base_select;
					next_r.rdata[`CTL_MODE_LSB +: 3] = r.mode;
				end
				`ADDR_PRIMARY: begin
					next_r.rdata = r.primary_compare_value;
				end
				`ADDR_SECONDARY: begin
					next_r.rdata = r.secondary_compare_value;
				end
				`ADDR_STATUS: begin
					next_r.rdata[`STS_PIN_BIT]   = r.pin;
					next_r.rdata[`STS_EVENT_BIT] = r.event_seen;
					next_r.rdata[`STS_DONE_BIT]  = r.pulse_done;
				end
				default: begin
					next_r.rdata = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign REG_RDATA             = r.rdata;
	assign COMPARE_OUTPUT_PIN    = r.pin;
	assign COMPARE_OUTPUT_ENABLE = (r.mode != MODE_OFF);
	assign COMPARE_EVENT = (r.mode == MODE_PWM_FLT) ? fault_fall : pin_event;

endmodule // output_compare_channel

// ===== test/compare_props.sv
`timescale 1ns/1ps
module compare_props #(
	parameter int TIMER_WIDTH = 16
) (
	// Clock and reset
	input wire logic                   CLK_SYS,
	input wire logic                   RST_B,
	// Register port
	input wire logic [2:0]             REG_ADDR,
	input wire logic [15:0]            REG_WDATA,
	input wire logic                   REG_WRITE,
	input wire logic                   REG_READ,
	input wire logic [15:0]            REG_RDATA,
	// Time bases
	input wire logic [TIMER_WIDTH-1:0] FIRST_TIMER,
	input wire logic                   FIRST_TIMER_ROLLOVER,
	input wire logic [TIMER_WIDTH-1:0] SECOND_TIMER,
	input wire logic                   SECOND_TIMER_ROLLOVER,
	// Processor state, fault, pin
	input wire logic                   CPU_IDLE,
	input wire logic                   SHARED_FAULT_INPUT,
	input wire logic                   COMPARE_OUTPUT_PIN,
	input wire logic                   COMPARE_OUTPUT_ENABLE,
	input wire logic                   COMPARE_EVENT
);
	logic [15:0]            ctl;
	logic [TIMER_WIDTH-1:0] prim;
	logic [TIMER_WIDTH-1:0] tmr;
	logic                   run;
	logic [2:0]             m;
	// Shadow of what software wrote, so causes can be named
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			ctl <= 16'h0000;
			prim <= '0;
		end else if (REG_WRITE && REG_ADDR == 3'h0) begin
			ctl <= REG_WDATA & 16'h200F;
		end else if (REG_WRITE && REG_ADDR == 3'h1) begin
			prim <= REG_WDATA[TIMER_WIDTH-1:0];
		end
	end
	assign m = ctl[2:0];
	assign tmr = ctl[3] ? SECOND_TIMER : FIRST_TIMER;
	assign run = !(ctl[13] && CPU_IDLE);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	property p_unimpl;
		$past(REG_READ) && $past(REG_ADDR) == 3'h0 |-> REG_RDATA[15:14] == 2'h0
			&& REG_RDATA[12:5] == 8'h00;
	endproperty
	a_unimpl: assert property (p_unimpl)
		else $error("reserved control bits read nonzero");
	property p_enable;
		COMPARE_OUTPUT_ENABLE == (m != 3'h0);
	endproperty
	a_enable: assert property (p_enable)
		else $error("pin enable disagrees with mode");
	property p_off;
		m == 3'h0 && $past(m) == 3'h0 && $past(m, 2) == 3'h0 |-> !COMPARE_EVENT;
	endproperty
	a_off: assert property (p_off)
		else $error("event while disabled");
	property p_match;
		m == 3'h1 && $past(m) == 3'h1 && run && !REG_WRITE && tmr == prim
			|=> COMPARE_OUTPUT_PIN;
	endproperty
	a_match: assert property (p_match)
		else $error("match on selected timer did not raise pin");
	property p_rise;
		m == 3'h1 && $rose(COMPARE_OUTPUT_PIN) |-> ##[0:1] COMPARE_EVENT;
	endproperty
	a_rise: assert property (p_rise)
		else $error("no event on rising pin");
	property p_fall;
		m == 3'h2 && $fell(COMPARE_OUTPUT_PIN) |-> ##[0:1] COMPARE_EVENT;
	endproperty
	a_fall: assert property (p_fall)
		else $error("no event on falling pin");
	property p_pwm;
		m == 3'h6 && $past(m) == 3'h6 && $past(m, 2) == 3'h6 |-> !COMPARE_EVENT;
	endproperty
	a_pwm: assert property (p_pwm)
		else $error("event in plain pwm");
	property p_idle;
		m == 3'h1 && !run && $past(!run) && !REG_WRITE |=> $stable(COMPARE_OUTPUT_PIN);
	endproperty
	a_idle: assert property (p_idle)
		else $error("pin moved while halted in idle");
	c_rise: cover property (m == 3'h1 && COMPARE_EVENT);
	c_flt: cover property (m == 3'h7 && COMPARE_EVENT);
	c_pwm: cover property (m == 3'h6 && $fell(COMPARE_OUTPUT_PIN));
endmodule // compare_props

bind output_compare_channel compare_props #(.TIMER_WIDTH(TIMER_WIDTH)) u_compare_props (
	.CLK_SYS, .RST_B, .REG_ADDR, .REG_WDATA, .REG_WRITE, .REG_READ, .REG_RDATA,
	.FIRST_TIMER, .FIRST_TIMER_ROLLOVER, .SECOND_TIMER, .SECOND_TIMER_ROLLOVER,
	.CPU_IDLE, .SHARED_FAULT_INPUT, .COMPARE_OUTPUT_PIN, .COMPARE_OUTPUT_ENABLE,
	.COMPARE_EVENT);

// ===== test/pin_load.sv
`timescale 1ns/1ps
module pin_load (
	// Driven pin
	input  wire logic pin,
	input  wire logic oe,
	// Level at the load
	output logic      line
);
	// Pull-down owns the line once the channel lets go
	assign line = oe ? pin : 1'b0;
endmodule // pin_load

// ===== test/output_compare_channel_bench.sv
`timescale 1ns/1ps
module output_compare_channel_bench;
	import compare_channel_pkg::*;
	typedef struct {
		logic [2:0] mode;
		logic       tsel;
		word_t      prim;
		word_t      sec;
		int         n_ev;
		logic       pin;
	} row_s;
	logic       clk, rst_b, wr, rd, r1, r2, idle, flt, pin, oe, ev, line;
	logic [2:0] addr;
	word_t      wdata, rdata, t1, t2, d;
	int         n_errors, check_count, n_seen, i;
	row_s       rows [7];
	output_compare_channel u_output_compare_channel (.CLK_SYS(clk), .RST_B(rst_b),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_WRITE(wr), .REG_READ(rd), .REG_RDATA(rdata),
		.FIRST_TIMER(t1), .FIRST_TIMER_ROLLOVER(r1), .SECOND_TIMER(t2),
		.SECOND_TIMER_ROLLOVER(r2), .CPU_IDLE(idle), .SHARED_FAULT_INPUT(flt),
		.COMPARE_OUTPUT_PIN(pin), .COMPARE_OUTPUT_ENABLE(oe), .COMPARE_EVENT(ev));
	pin_load u_pin_load (.pin(pin), .oe(oe), .line(line));
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) if (ev === 1'b1) n_seen <= n_seen + 1;
	task check(input string what, input word_t seen, input word_t exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task wreg(input logic [2:0] a, input word_t v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	task rreg(input logic [2:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 d = rdata;
	endtask
	// Unselected timer sits on the compare value: a wrong select matches at once
	task sweep(input logic s, input int n, input word_t p);
		for (int k = 0; k < n * 10; k++) begin
			@(posedge clk);
			t1 <= s ? p : word_t'(k % 10);
			t2 <= s ? word_t'(k % 10) : p;
			r1 <= !s && k % 10 == 9;
			r2 <= s && k % 10 == 9;
		end
		@(posedge clk);
		r1 <= 0;
		r2 <= 0;
		repeat (3) @(posedge clk);
	endtask
	task park;
		t1 <= 16'h00FF;
		t2 <= 16'h00FF;
	endtask
	initial begin
		rows = '{
			'{3'h0, 1'b0, 16'h0005, 16'h0000, 0, 1'b0},
			'{3'h1, 1'b0, 16'h0005, 16'h0000, 1, 1'b1},
			'{3'h2, 1'b1, 16'h0005, 16'h0000, 1, 1'b0},
			'{3'h3, 1'b0, 16'h0005, 16'h0000, 2, 1'b0},
			'{3'h4, 1'b1, 16'h0003, 16'h0006, 1, 1'b0},
			'{3'h5, 1'b0, 16'h0003, 16'h0006, 2, 1'b0},
			'{3'h6, 1'b1, 16'h0003, 16'h0006, 0, 1'b1}};
		{rst_b, wr, rd, r1, r2, idle, addr, wdata} = '0;
		flt = 1;
		t1 = 16'h00FF;
		t2 = 16'h00FF;
		repeat (8) @(posedge clk);
		rst_b <= 1;
		#1 check("pin rst", word_t'(pin), 16'h0000);
		check("oe rst", word_t'(oe), 16'h0000);
		rreg(3'h0);
		check("ctl rst", d, 16'h0000);
		wreg(3'h0, 16'hFFFF);
		rreg(3'h0);
		check("ctl mask", d, 16'h200F);
		rreg(3'h5);
		check("unmapped", d, 16'h0000);
		foreach (rows[j]) begin
			park();
			wreg(3'h1, rows[j].prim);
			wreg(3'h2, rows[j].sec);
			n_seen = 0;
			wreg(3'h0, {12'h000, rows[j].tsel, rows[j].mode});
			rreg(3'h0);
			check("ctl", d, {12'h000, rows[j].tsel, rows[j].mode});
			check("oe", word_t'(oe), word_t'(rows[j].mode != 3'h0));
			sweep(rows[j].tsel, 2, rows[j].prim);
			check("events", word_t'(n_seen), word_t'(rows[j].n_ev));
			if (rows[j].mode != 3'h0) check("pin", word_t'(line), word_t'(rows[j].pin));
		end
		rreg(3'h3);
		check("status", d, 16'h0003);
		rreg(3'h3);
		check("status clr", d, 16'h0001);
		park();
		wreg(3'h1, 16'h0005);
		wreg(3'h0, 16'h2001);
		idle <= 1;
		sweep(1'b0, 1, 16'h0005);
		check("idle pin", word_t'(line), 16'h0000);
		idle <= 0;
		sweep(1'b0, 1, 16'h0005);
		check("wake pin", word_t'(line), 16'h0001);
		park();
		wreg(3'h1, 16'h0003);
		wreg(3'h2, 16'h0006);
		wreg(3'h0, 16'h0007);
		sweep(1'b0, 1, 16'h0003);
		n_seen = 0;
		@(posedge clk);
		flt <= 0;
		for (i = 0; i < 20 && n_seen == 0; i++) @(posedge clk);
		check("fault event", word_t'(n_seen), 16'h0001);
		if (n_seen == 0) end_of_test();
		rreg(3'h0);
		check("fault flag", d, 16'h0017);
		sweep(1'b0, 1, 16'h0003);
		check("fault pin", word_t'(line), 16'h0000);
		flt <= 1;
		wreg(3'h0, 16'h0007);
		rreg(3'h0);
		check("flag clear", d, 16'h0007);
		end_of_test();
	end
endmodule // output_compare_channel_bench
